//--- rtl/ain_cfg_pkg.sv
// Summary of operation
// - precision index 0 selects the variant default: 5, 8 or 9
// - accepted precision index range is 0-5, 0-8 or 0-12 by variant
// - precision indexes 9 to 12 route conversions to the 24-bit sigma-delta converter
// - a larger precision index from 1 up gives a longer sample time; index 0 takes the variant default's time
// - global precision write sets all channels; read gives common value or 0xFFFF
// - per-channel indexes serve command-response readings; stream uses its own index
// - inhibit bit set to 1 blocks state, direction and analog-enable writes
// - analog-enable bit 1 means analog, 0 digital; analog-to-digital makes an input
// - analog-enable writes are filtered bitwise by the inhibit mask
// - flexible lines are channels 4 to 11; mask bit equals channel number
// - channels 0 to 3 stay dedicated analog inputs, never digital
// - a command-response analog read on a flexible line makes that line analog; stream reads do not
// - reference value 199 means single-ended; another channel means differential
// - global reference write 1 or 199 sets all; read gives 1, 199 or 0xFFFF
// - differential pairs are even positive, next odd negative; odd entries not written
// - channels 14 and 15 never read differentially
// - gain x1, x10, x100, x1000 for spans of 10, 1, 0.1, 0.01 volts
// - span write gives highest expected voltage; global span sets all, mixed reads -9999
// - span writes round up to a supported span, above 10.0 round down; default 10
// - per-channel float registers step by two addresses, 16-bit ones by one
package ain_cfg_pkg;

  // -------------------------------------------------------------------
  // register addresses (16-bit word addresses)
  // -------------------------------------------------------------------
  localparam logic [15:0] ADDR_SPAN_BASE = 16'h9C40;
  localparam logic [15:0] ADDR_REF_BASE  = 16'hA028;
  localparam logic [15:0] ADDR_PREC_BASE = 16'hA21C;
  localparam logic [15:0] ADDR_GSPAN     = 16'hAB7C;
  localparam logic [15:0] ADDR_GREF      = 16'hAB7E;
  localparam logic [15:0] ADDR_GPREC     = 16'hAB7F;
  localparam logic [15:0] ADDR_AEN       = 16'h0B40;
  localparam logic [15:0] ADDR_INH       = 16'h0B54;
  localparam logic [15:0] ADDR_SPREC     = 16'h0FAA;

  // -------------------------------------------------------------------
  // channel layout and special values
  // -------------------------------------------------------------------
  localparam int          NUM_CH       = 14;
  localparam logic [31:0] FLEX_MASK    = 32'h00000FF0;
  localparam logic [15:0] REF_SINGLE   = 16'h00C7;
  localparam logic [15:0] REF_ALL_DIFF = 16'h0001;
  localparam logic [15:0] MIXED_U16    = 16'hFFFF;
  localparam logic [31:0] MIXED_F32    = 32'hC61C3C00;
  localparam logic [3:0]  CH_TEMP      = 4'hE;
  localparam logic [3:0]  CH_GND       = 4'hF;

  // -------------------------------------------------------------------
  // span thresholds and read-back values (IEEE single)
  // -------------------------------------------------------------------
  localparam logic [31:0] F_0P01 = 32'h3C23D70A;
  localparam logic [31:0] F_0P1  = 32'h3DCCCCCD;
  localparam logic [31:0] F_1    = 32'h3F800000;
  localparam logic [31:0] F_10   = 32'h41200000;

  typedef enum logic [1:0] {
    SPAN_10V   = 2'h0,
    SPAN_1V    = 2'h1,
    SPAN_100MV = 2'h2,
    SPAN_10MV  = 2'h3
  } span_t;

  typedef enum logic [1:0] {
    VAR_LOW   = 2'h0,
    VAR_BASE  = 2'h1,
    VAR_HIRES = 2'h2
  } variant_t;

  // -------------------------------------------------------------------
  // precision index limits and reset values
  // -------------------------------------------------------------------
  localparam logic [3:0]  DEF_IDX_LOW   = 4'h5;
  localparam logic [3:0]  DEF_IDX_BASE  = 4'h8;
  localparam logic [3:0]  DEF_IDX_HIRES = 4'h9;
  localparam logic [3:0]  MAX_IDX_LOW   = 4'h5;
  localparam logic [3:0]  MAX_IDX_BASE  = 4'h8;
  localparam logic [3:0]  MAX_IDX_HIRES = 4'hC;
  localparam logic [3:0]  ALT_ADC_IDX   = 4'h9;
  localparam logic [3:0]  PREC_RESET    = 4'h0;
  localparam logic [31:0] INH_RESET     = 32'h00000000;
  localparam logic [31:0] AEN_RESET     = 32'h00000FF0;
  localparam int          SAMPLE_BASE   = 16;

endpackage

//--- rtl/ain_cfg_regs.sv
`timescale 1ns/1ns
module ain_cfg_regs #(
  parameter ain_cfg_pkg::variant_t VARIANT     = ain_cfg_pkg::VAR_HIRES,
  parameter int                    NUM_CH      = ain_cfg_pkg::NUM_CH,
  parameter int                    SAMPLE_BASE = ain_cfg_pkg::SAMPLE_BASE
) (
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        reset_i,
  // register word port
  input  wire logic [15:0] reg_addr_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [15:0] reg_wdata_i,
  output logic      [15:0] reg_rdata_o,
  output logic             reg_ack_o,
  output logic             reg_err_o,
  // conversion request from the sequencer
  input  wire logic        conv_req_i,
  input  wire logic [3:0]  conv_ch_i,
  input  wire logic        conv_stream_i,
  // conversion setup to the front end
  output logic             conv_valid_o,
  output logic      [3:0]  conv_channel_o,
  output logic      [3:0]  conv_idx_o,
  output logic             conv_alt_adc_o,
  output logic      [31:0] conv_sample_cycles_o,
  output logic      [1:0]  conv_gain_o,
  output logic             conv_diff_o,
  output logic      [15:0] conv_neg_ch_o,
  // line configuration
  output logic      [31:0] analog_enable_o,
  output logic      [31:0] write_inhibit_o,
  output logic      [31:0] force_input_o
);

  // -------------------------------------------------------------------
  // helper functions
  // -------------------------------------------------------------------
  function automatic logic [3:0] max_idx();
    case (VARIANT)
      ain_cfg_pkg::VAR_LOW:  max_idx = ain_cfg_pkg::MAX_IDX_LOW;
      ain_cfg_pkg::VAR_BASE: max_idx = ain_cfg_pkg::MAX_IDX_BASE;
      default:               max_idx = ain_cfg_pkg::MAX_IDX_HIRES;
    endcase
  endfunction

  // zero stands for the variant default
  function automatic logic [3:0] eff_idx(input logic [3:0] raw);
    if (raw != 4'h0) begin
      eff_idx = raw;
    end else begin
      case (VARIANT)
        ain_cfg_pkg::VAR_LOW:  eff_idx = ain_cfg_pkg::DEF_IDX_LOW;
        ain_cfg_pkg::VAR_BASE: eff_idx = ain_cfg_pkg::DEF_IDX_BASE;
        default:               eff_idx = ain_cfg_pkg::DEF_IDX_HIRES;
      endcase
    end
  endfunction

  // positive floats order like unsigned words, so the sign bit is dropped
  function automatic logic [1:0] float_to_span(input logic [31:0] f);
    logic [31:0] mag;
    mag = {1'b0, f[30:0]};
    if (mag <= ain_cfg_pkg::F_0P01) begin
      float_to_span = ain_cfg_pkg::SPAN_10MV;
    end else if (mag <= ain_cfg_pkg::F_0P1) begin
      float_to_span = ain_cfg_pkg::SPAN_100MV;
    end else if (mag <= ain_cfg_pkg::F_1) begin
      float_to_span = ain_cfg_pkg::SPAN_1V;
    end else begin
      float_to_span = ain_cfg_pkg::SPAN_10V;    // above 10 rounds down
    end
  endfunction

  function automatic logic [31:0] span_to_float(input logic [1:0] s);
    case (s)
      ain_cfg_pkg::SPAN_1V:    span_to_float = ain_cfg_pkg::F_1;
      ain_cfg_pkg::SPAN_100MV: span_to_float = ain_cfg_pkg::F_0P1;
      ain_cfg_pkg::SPAN_10MV:  span_to_float = ain_cfg_pkg::F_0P01;
      default:                 span_to_float = ain_cfg_pkg::F_10;
    endcase
  endfunction

  // -------------------------------------------------------------------
  // storage
  // -------------------------------------------------------------------
  logic [3:0]  prec_r [NUM_CH];
  logic [1:0]  span_r [NUM_CH];
  logic [15:0] ref_r  [NUM_CH];
  logic [3:0]  sprec_r;
  logic [31:0] inh_r;
  logic [31:0] aen_r;
  logic [15:0] hi_stage_r;

  // -------------------------------------------------------------------
  // address decode
  // -------------------------------------------------------------------
  logic [15:0] span_off;
  logic [15:0] ref_off;
  logic [15:0] prec_off;
  logic        span_hit;
  logic        ref_hit;
  logic        prec_hit;
  logic [3:0]  span_ch;
  logic [3:0]  ref_ch;
  logic [3:0]  prec_ch;
  logic        hit_gspan;
  logic        hit_gref;
  logic        hit_gprec;
  logic        hit_aen;
  logic        hit_inh;
  logic        hit_sprec;
  logic        mapped;
  logic [31:0] wr_word;

  // float registers take two words each, 16-bit ones one word
  assign span_off  = reg_addr_i - ain_cfg_pkg::ADDR_SPAN_BASE;
  assign ref_off   = reg_addr_i - ain_cfg_pkg::ADDR_REF_BASE;
  assign prec_off  = reg_addr_i - ain_cfg_pkg::ADDR_PREC_BASE;
  assign span_hit  = span_off < 16'(2 * NUM_CH);
  assign ref_hit   = ref_off < 16'(NUM_CH);
  assign prec_hit  = prec_off < 16'(NUM_CH);
  assign span_ch   = span_off[4:1];
  assign ref_ch    = ref_off[3:0];
  assign prec_ch   = prec_off[3:0];
  assign hit_gspan = reg_addr_i[15:1] == ain_cfg_pkg::ADDR_GSPAN[15:1];
  assign hit_gref  = reg_addr_i == ain_cfg_pkg::ADDR_GREF;
  assign hit_gprec = reg_addr_i == ain_cfg_pkg::ADDR_GPREC;
  assign hit_aen   = reg_addr_i[15:1] == ain_cfg_pkg::ADDR_AEN[15:1];
  assign hit_inh   = reg_addr_i[15:1] == ain_cfg_pkg::ADDR_INH[15:1];
  assign hit_sprec = reg_addr_i[15:1] == ain_cfg_pkg::ADDR_SPREC[15:1];
  assign mapped    = span_hit | ref_hit | prec_hit | hit_gspan | hit_gref |
                     hit_gprec | hit_aen | hit_inh | hit_sprec;
  // 32-bit values: high word written first and staged, low word commits
  assign wr_word   = {hi_stage_r, reg_wdata_i};

  // -------------------------------------------------------------------
  // aggregate state for the global registers
  // -------------------------------------------------------------------
  logic prec_same;
  logic span_same;
  logic all_single;
  logic all_diff;

  always_comb begin
    prec_same  = 1'b1;
    span_same  = 1'b1;
    all_single = 1'b1;
    all_diff   = 1'b1;
    for (int i = 0; i < NUM_CH; i++) begin
      if (prec_r[i] != prec_r[0]) begin
        prec_same = 1'b0;
      end
      if (span_r[i] != span_r[0]) begin
        span_same = 1'b0;
      end
      if (ref_r[i] != ain_cfg_pkg::REF_SINGLE) begin
        all_single = 1'b0;
      end
      // odd entries stay single-ended when every pair is differential
      if ((i % 2 == 0) && (ref_r[i] != 16'(i + 1))) begin
        all_diff = 1'b0;
      end
      if ((i % 2 == 1) && (ref_r[i] != ain_cfg_pkg::REF_SINGLE)) begin
        all_diff = 1'b0;
      end
    end
  end

  // -------------------------------------------------------------------
  // write side
  // -------------------------------------------------------------------
  logic wr_lo;

  assign wr_lo = reg_wr_i & reg_addr_i[0];

  // high word staging for the 32-bit registers
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      hi_stage_r <= 16'h0000;
    end else if (reg_wr_i && !reg_addr_i[0]) begin
      hi_stage_r <= reg_wdata_i;
    end
  end

  // per-channel and global precision index
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      for (int i = 0; i < NUM_CH; i++) begin
        prec_r[i] <= ain_cfg_pkg::PREC_RESET;
      end
    end else if (reg_wr_i && reg_wdata_i <= 16'(max_idx())) begin
      if (prec_hit) begin
        prec_r[prec_ch] <= reg_wdata_i[3:0];
      end else if (hit_gprec) begin
        for (int i = 0; i < NUM_CH; i++) begin
          prec_r[i] <= reg_wdata_i[3:0];
        end
      end
    end
  end

  // stream index is held apart from the command-response indexes
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      sprec_r <= ain_cfg_pkg::PREC_RESET;
    end else if (wr_lo && hit_sprec && wr_word <= 32'(max_idx())) begin
      sprec_r <= reg_wdata_i[3:0];
    end
  end

  // span: the value is rounded to a gain code as it is stored
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      for (int i = 0; i < NUM_CH; i++) begin
        span_r[i] <= ain_cfg_pkg::SPAN_10V;
      end
    end else if (wr_lo && span_hit) begin
      span_r[span_ch] <= float_to_span(wr_word);
    end else if (wr_lo && hit_gspan) begin
      for (int i = 0; i < NUM_CH; i++) begin
        span_r[i] <= float_to_span(wr_word);
      end
    end
  end

  // reference select; odd entries are ignored since only even ones pair
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      for (int i = 0; i < NUM_CH; i++) begin
        ref_r[i] <= ain_cfg_pkg::REF_SINGLE;
      end
    end else if (reg_wr_i && ref_hit && !ref_ch[0]) begin
      ref_r[ref_ch] <= reg_wdata_i;
    end else if (reg_wr_i && hit_gref) begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (reg_wdata_i == ain_cfg_pkg::REF_SINGLE) begin
          ref_r[i] <= ain_cfg_pkg::REF_SINGLE;
        end else if (reg_wdata_i == ain_cfg_pkg::REF_ALL_DIFF) begin
          ref_r[i] <= (i % 2 == 0) ? 16'(i + 1) : ain_cfg_pkg::REF_SINGLE;
        end
      end
    end
  end

  // inhibit mask covers the whole line set; only the enable bits act here
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      inh_r <= ain_cfg_pkg::INH_RESET;
    end else if (wr_lo && hit_inh) begin
      inh_r <= wr_word;
    end
  end

  // analog enable: only flexible lines are held, channels 0-3 never switch
  logic [31:0] aen_wr;
  logic [31:0] aen_auto;
  logic [31:0] aen_nxt;

  assign aen_wr   = ain_cfg_pkg::FLEX_MASK & ~inh_r;
  assign aen_auto = (conv_req_i && !conv_stream_i &&
                     ain_cfg_pkg::FLEX_MASK[conv_ch_i]) ?
                    (32'h00000001 << conv_ch_i) : 32'h00000000;

  always_comb begin
    aen_nxt = aen_r;
    if (wr_lo && hit_aen) begin
      aen_nxt = (aen_r & ~aen_wr) | (wr_word & aen_wr);
    end
    // a read that arrives with a write still leaves its line analog
    aen_nxt = aen_nxt | aen_auto;
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      aen_r <= ain_cfg_pkg::AEN_RESET;
    end else begin
      aen_r <= aen_nxt;
    end
  end

  // lines leaving analog mode are turned to inputs, one-cycle pulse
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      force_input_o <= 32'h00000000;
    end else begin
      force_input_o <= aen_r & ~aen_nxt;
    end
  end

  assign analog_enable_o = aen_r;
  assign write_inhibit_o = inh_r;

  // -------------------------------------------------------------------
  // read side
  // -------------------------------------------------------------------
  logic [31:0] rd_word;

  always_comb begin
    rd_word = 32'h00000000;
    if (span_hit) begin
      rd_word = span_to_float(span_r[span_ch]);
    end else if (ref_hit) begin
      rd_word = {16'h0000, ref_r[ref_ch]};
    end else if (prec_hit) begin
      rd_word = {28'h0000000, prec_r[prec_ch]};
    end else if (hit_gspan) begin
      rd_word = span_same ? span_to_float(span_r[0]) : ain_cfg_pkg::MIXED_F32;
    end else if (hit_gref) begin
      if (all_single) begin
        rd_word = {16'h0000, ain_cfg_pkg::REF_SINGLE};
      end else if (all_diff) begin
        rd_word = {16'h0000, ain_cfg_pkg::REF_ALL_DIFF};
      end else begin
        rd_word = {16'h0000, ain_cfg_pkg::MIXED_U16};
      end
    end else if (hit_gprec) begin
      rd_word = prec_same ? {28'h0000000, prec_r[0]} :
                            {16'h0000, ain_cfg_pkg::MIXED_U16};
    end else if (hit_aen) begin
      rd_word = aen_r;
    end else if (hit_inh) begin
      rd_word = inh_r;
    end else if (hit_sprec) begin
      rd_word = {28'h0000000, sprec_r};
    end
  end

  // answer one cycle after any strobe; unmapped addresses flag an error
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      reg_rdata_o <= 16'h0000;
      reg_ack_o   <= 1'b0;
      reg_err_o   <= 1'b0;
    end else begin
      reg_ack_o   <= reg_rd_i | reg_wr_i;
      reg_err_o   <= (reg_rd_i | reg_wr_i) & ~mapped;
      // 16-bit registers use the low word at their single address
      if (!reg_rd_i) begin
        reg_rdata_o <= 16'h0000;
      end else if (ref_hit || prec_hit || hit_gref || hit_gprec || reg_addr_i[0]) begin
        reg_rdata_o <= rd_word[15:0];
      end else begin
        reg_rdata_o <= rd_word[31:16];
      end
    end
  end

  // -------------------------------------------------------------------
  // conversion setup
  // -------------------------------------------------------------------
  logic        ch_real;
  logic [3:0]  sel_idx;
  logic [1:0]  sel_span;
  logic [15:0] sel_ref;
  logic        sel_diff;

  assign ch_real = 32'(conv_ch_i) < 32'(NUM_CH);

  // stream readings ignore the per-channel index; 14 and 15 read single-ended
  always_comb begin
    sel_idx  = conv_stream_i ? eff_idx(sprec_r) :
               eff_idx(ch_real ? prec_r[conv_ch_i] : ain_cfg_pkg::PREC_RESET);
    sel_span = ch_real ? span_r[conv_ch_i] : ain_cfg_pkg::SPAN_10V;
    sel_ref  = ch_real ? ref_r[conv_ch_i] : ain_cfg_pkg::REF_SINGLE;
    sel_diff = ch_real && (sel_ref != ain_cfg_pkg::REF_SINGLE);
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      conv_valid_o         <= 1'b0;
      conv_channel_o       <= 4'h0;
      conv_idx_o           <= 4'h0;
      conv_alt_adc_o       <= 1'b0;
      conv_sample_cycles_o <= 32'h00000000;
      conv_gain_o          <= ain_cfg_pkg::SPAN_10V;
      conv_diff_o          <= 1'b0;
      conv_neg_ch_o        <= ain_cfg_pkg::REF_SINGLE;
    end else begin
      conv_valid_o <= conv_req_i;
      if (conv_req_i) begin
        conv_channel_o       <= conv_ch_i;
        conv_idx_o           <= sel_idx;
        conv_alt_adc_o       <= sel_idx >= ain_cfg_pkg::ALT_ADC_IDX;
        conv_sample_cycles_o <= 32'(SAMPLE_BASE) << sel_idx;
        conv_gain_o          <= sel_span;
        conv_diff_o          <= sel_diff;
        conv_neg_ch_o        <= sel_ref;
      end
    end
  end

endmodule

//--- verification/ain_cfg_regs_assertions.sv
`timescale 1ns/1ns
module ain_cfg_regs_chk #(
  parameter int SAMPLE_BASE = 16
) (
  // clock and reset
  input wire logic        sys_clk_i,
  input wire logic        reset_i,
  // register port
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic        reg_ack_o,
  // conversion port
  input wire logic        conv_req_i,
  input wire logic [3:0]  conv_ch_i,
  input wire logic        conv_stream_i,
  input wire logic        conv_valid_o,
  input wire logic [3:0]  conv_channel_o,
  input wire logic [3:0]  conv_idx_o,
  input wire logic        conv_alt_adc_o,
  input wire logic [31:0] conv_sample_cycles_o,
  input wire logic        conv_diff_o,
  input wire logic [15:0] conv_neg_ch_o,
  input wire logic [31:0] analog_enable_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  // ------------------------------------------------
  // handshake and conversion setup
  // ------------------------------------------------
  ack_after_strobe_a: assert property ((reg_wr_i || reg_rd_i) |=> reg_ack_o)
    else $error("no answer after strobe");
  ack_has_cause_a: assert property (reg_ack_o |-> $past(reg_wr_i) || $past(reg_rd_i))
    else $error("answer without strobe");
  conv_answer_a: assert property (conv_req_i |=> conv_valid_o)
    else $error("no setup after request");
  default_index_a: assert property (conv_valid_o |-> conv_idx_o != 4'h0)
    else $error("zero index reached front end");
  alt_route_a: assert property (conv_valid_o |-> conv_alt_adc_o == (conv_idx_o >= 4'h9))
    else $error("converter route wrong");
  sample_length_a: assert property (conv_valid_o |->
    conv_sample_cycles_o == (32'(SAMPLE_BASE) << conv_idx_o))
    else $error("sample length wrong");
  diff_by_ref_a: assert property (
    conv_valid_o |-> conv_diff_o == (conv_neg_ch_o != 16'h00C7))
    else $error("diff flag disagrees with reference");
  special_single_a: assert property (
    conv_valid_o && conv_channel_o >= 4'hE |-> !conv_diff_o)
    else $error("special channel read differentially");
  // a command read on a flexible line forces analog mode next cycle
  auto_analog_a: assert property (
    conv_req_i && !conv_stream_i && conv_ch_i inside {[4:11]}
    |=> analog_enable_o[$past(conv_ch_i)])
    else $error("line not made analog by read");
endmodule

bind ain_cfg_regs ain_cfg_regs_chk #(.SAMPLE_BASE(SAMPLE_BASE)) i_chk (
  .sys_clk_i(sys_clk_i), .reset_i(reset_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_ack_o(reg_ack_o), .conv_req_i(conv_req_i), .conv_ch_i(conv_ch_i),
  .conv_stream_i(conv_stream_i), .conv_valid_o(conv_valid_o),
  .conv_channel_o(conv_channel_o), .conv_idx_o(conv_idx_o),
  .conv_alt_adc_o(conv_alt_adc_o), .conv_sample_cycles_o(conv_sample_cycles_o),
  .conv_diff_o(conv_diff_o), .conv_neg_ch_o(conv_neg_ch_o),
  .analog_enable_o(analog_enable_o));

//--- verification/host_model.sv
`timescale 1ns/1ns
module host_model (
  // clock
  input  wire logic        sys_clk_i,
  // register port
  output logic      [15:0] reg_addr_o,
  output logic             reg_wr_o,
  output logic             reg_rd_o,
  output logic      [15:0] reg_wdata_o,
  input  wire logic [15:0] reg_rdata_i,
  input  wire logic        reg_ack_i,
  input  wire logic        reg_err_i
);
  initial begin
    reg_addr_o  = 16'h0000;
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
    reg_wdata_o = 16'h0000;
  end
  // one word access; strobe is a one-cycle pulse, address held until the answer
  task automatic access(input logic w, input logic [15:0] a, input logic [15:0] d,
                        output logic [15:0] q, output logic e, output logic ok);
    int n;
    n = 0;
    q = 16'h0000;
    e = 1'b0;
    ok = 1'b1;
    // odd reference entries belong to a pair and are left alone
    if (w && a >= 16'hA028 && a < 16'hA036 && a[0]) return;
    @(posedge sys_clk_i);
    reg_addr_o  <= a;
    reg_wdata_o <= d;
    reg_wr_o    <= w;
    reg_rd_o    <= !w;
    @(posedge sys_clk_i);
    reg_wr_o <= 1'b0;
    reg_rd_o <= 1'b0;
    #1;
    while (reg_ack_i !== 1'b1 && n < 4) begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    ok = (reg_ack_i === 1'b1);
    q = reg_rdata_i;
    e = reg_err_i;
  endtask
endmodule

//--- verification/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  localparam int SB = 16;
  logic sys_clk_i = 1'b0, reset_i = 1'b1, conv_req_i = 1'b0, conv_stream_i = 1'b0;
  logic [3:0] conv_ch_i = 4'h0;
  logic [15:0] addr, wdata, rdata, q;
  logic wr, rd, ack, err, e, ok, valid, alt, diff;
  logic [3:0] chan, idx;
  logic [31:0] cyc, aen, inh, fin;
  logic [1:0] gain;
  logic [15:0] neg;
  logic [3:0] low_idx;
  logic low_alt;
  int error_cnt = 0, checks = 0;
  // write rows carry data, read rows carry the expected word
  logic [32:0] rows [38] = '{
    {1'b0,16'hAB7E,16'h00C7}, {1'b0,16'hAB7F,16'h0000},
    {1'b1,16'hA21D,16'h0004}, {1'b0,16'hA21D,16'h0004},
    {1'b1,16'hA21D,16'h000D}, {1'b0,16'hA21D,16'h0004},
    {1'b1,16'hA21D,16'h000C}, {1'b0,16'hAB7F,16'hFFFF},
    {1'b1,16'hAB7F,16'h000C}, {1'b0,16'hA21C,16'h000C}, {1'b0,16'hAB7F,16'h000C},
    {1'b1,16'hA02A,16'h0003}, {1'b0,16'hAB7E,16'hFFFF},
    {1'b1,16'hAB7E,16'h0001}, {1'b0,16'hAB7E,16'h0001},
    {1'b0,16'hA02B,16'h00C7}, {1'b0,16'hA02C,16'h0005},
    {1'b1,16'hAB7E,16'h00C7}, {1'b0,16'hA02A,16'h00C7},
    {1'b1,16'h9C42,16'h3F00}, {1'b1,16'h9C43,16'h0000}, {1'b0,16'h9C42,16'h3F80},
    {1'b0,16'hAB7D,16'h3C00}, {1'b1,16'hAB7C,16'h4170}, {1'b1,16'hAB7D,16'h0000},
    {1'b0,16'hAB7C,16'h4120}, {1'b0,16'h9C42,16'h4120},
    {1'b1,16'h0B54,16'h0000}, {1'b1,16'h0B55,16'h0020},
    {1'b1,16'h0B40,16'h0000}, {1'b1,16'h0B41,16'h0000}, {1'b0,16'h0B41,16'h0020},
    {1'b1,16'h0FAA,16'h0000}, {1'b1,16'h0FAB,16'h000B}, {1'b0,16'h0FAB,16'h000B},
    {1'b1,16'hAB7E,16'h0001}, {1'b1,16'hAB7F,16'h000C}, {1'b0,16'h0FAA,16'h0000}};
  // span words for 10, 1, 0.1 and 0.01 volts, the highest expected input
  logic [31:0] spans [4] = '{32'h41200000, 32'h3F800000, 32'h3DCCCCCD, 32'h3C23D70A};

  always #2 sys_clk_i = ~sys_clk_i;

  ain_cfg_regs #(.SAMPLE_BASE(SB)) i_dut (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .reg_addr_i(addr), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_ack_o(ack),
    .reg_err_o(err), .conv_req_i(conv_req_i), .conv_ch_i(conv_ch_i),
    .conv_stream_i(conv_stream_i), .conv_valid_o(valid), .conv_channel_o(chan),
    .conv_idx_o(idx), .conv_alt_adc_o(alt), .conv_sample_cycles_o(cyc),
    .conv_gain_o(gain), .conv_diff_o(diff), .conv_neg_ch_o(neg),
    .analog_enable_o(aen), .write_inhibit_o(inh), .force_input_o(fin));
  // low-cost variant on the same bus: only its index handling is watched
  ain_cfg_regs #(.VARIANT(ain_cfg_pkg::VAR_LOW), .SAMPLE_BASE(SB)) i_dut_low (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .reg_addr_i(addr), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(), .reg_ack_o(), .reg_err_o(),
    .conv_req_i(conv_req_i), .conv_ch_i(conv_ch_i), .conv_stream_i(conv_stream_i),
    .conv_valid_o(), .conv_channel_o(), .conv_idx_o(low_idx), .conv_alt_adc_o(low_alt),
    .conv_sample_cycles_o(), .conv_gain_o(), .conv_diff_o(), .conv_neg_ch_o(),
    .analog_enable_o(), .write_inhibit_o(), .force_input_o());
  host_model i_host (
    .sys_clk_i(sys_clk_i), .reg_addr_o(addr), .reg_wr_o(wr), .reg_rd_o(rd),
    .reg_wdata_o(wdata), .reg_rdata_i(rdata), .reg_ack_i(ack), .reg_err_i(err));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    if (error_cnt == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // one reading request; outputs are looked at once the answer edge has settled
  task automatic conv(input logic [3:0] c, input logic s);
    @(posedge sys_clk_i);
    conv_req_i <= 1'b1;
    conv_ch_i <= c;
    conv_stream_i <= s;
    @(posedge sys_clk_i);
    conv_req_i <= 1'b0;
    #1;
    chk(32'(valid), 32'h1);
  endtask

  // watchdog: the whole run needs well under 5000 cycles
  initial begin
    #20000;
    error_cnt++;
    print_verdict();
  end

  initial begin
    repeat (3) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    #1;
    chk(aen, 32'h00000FF0);
    chk(32'(neg), 32'h00C7);
    foreach (rows[i]) begin
      i_host.access(rows[i][32], rows[i][31:16], rows[i][15:0], q, e, ok);
      chk(32'(ok), 32'h1);
      if (!rows[i][32]) chk(32'(q), 32'(rows[i][15:0]));
    end
    chk(inh, 32'h00000020);
    chk(aen, 32'h00000020);
    conv(4'h2, 1'b0);
    chk({chan, idx, 6'h0, alt, diff, neg}, {4'h2, 4'hC, 6'h0, 1'b1, 1'b1, 16'h0003});
    chk(32'({low_idx, low_alt}), 32'({4'h5, 1'b0}));
    chk(cyc, 32'(SB) << 12);
    conv(4'hE, 1'b0);
    chk(32'(diff), 32'h0);
    conv(4'h1, 1'b1);
    chk(32'({idx, alt}), 32'({4'hB, 1'b1}));
    chk(cyc, 32'(SB) << 11);
    conv(4'h6, 1'b0);
    chk(32'(aen[6]), 32'h1);
    // clearing the mask drops line 6 to digital; line 5 stays inhibited
    i_host.access(1'b1, 16'h0B40, 16'h0000, q, e, ok);
    i_host.access(1'b1, 16'h0B41, 16'h0000, q, e, ok);
    chk(fin, 32'h00000040);
    chk(aen, 32'h00000020);
    i_host.access(1'b1, 16'hAB7F, 16'h0000, q, e, ok);
    conv(4'h0, 1'b0);
    chk(32'({idx, alt}), 32'({4'h9, 1'b1}));
    chk(32'({low_idx, low_alt}), 32'({4'h5, 1'b0}));
    for (int g = 0; g < 4; g++) begin
      i_host.access(1'b1, 16'h9C40, spans[g][31:16], q, e, ok);
      i_host.access(1'b1, 16'h9C41, spans[g][15:0], q, e, ok);
      conv(4'h0, 1'b0);
      chk(32'(gain), 32'(g));
    end
    i_host.access(1'b0, 16'h1234, 16'h0000, q, e, ok);
    chk({q, 15'h0, e}, {16'h0000, 15'h0, 1'b1});
    print_verdict();
  end
endmodule
